// ===== cpc_top.sv
`timescale 1ns/1ns
// Function
// - normal range enables both switches
// - overcharge disables charge after delay
// - short dips ignored, long dips restart
// - low load-sense while charging stops charge
// - abnormal check needs discharge switch on
// - abnormal state left below abnormal level
// - overcharge release after release delay
// - load after charger re-enables charge
// - overdischarge disables discharge after delay
// - charger detect releases above threshold
// - mid load-sense releases at release level
// - no charger: release after release delay
// - excess current low disables discharge
// - excess current high disables faster
// - excess states recover below low threshold
// - short circuit disables after short delay
// - zero-volt charge: charge on, discharge off
// - zero-volt charge ends at threshold
// - overcharge reset delay 23 ms
// - overdischarge release delay 2.2 ms
// - excess current high delay 1.1 ms
// - short circuit delay 140 us
module cpc_top
    import cpc_pkg::*;
#(
    parameter int OVC_DET = OVC_DET_CYC,
    parameter int OVC_RST = OVC_RST_CYC,
    parameter int OVC_REL = OVC_REL_CYC,
    parameter int ABN_DET = ABN_DET_CYC,
    parameter int OVD_DET = OVD_DET_CYC,
    parameter int OVD_REL = OVD_REL_CYC,
    parameter int EXL_DET = EXL_DET_CYC,
    parameter int EXH_DET = EXH_DET_CYC,
    parameter int SHT_DET = SHT_DET_CYC
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // cell voltage comparators
    input  wire logic above_overcharge_threshold_i,
    input  wire logic below_overcharge_release_level_i,
    input  wire logic below_overdischarge_threshold_i,
    input  wire logic above_overdischarge_release_level_i,
    // load-sense and charger comparators
    input  wire logic load_sense_below_charger_detect_i,
    input  wire logic load_sense_above_excess_current_low_i,
    input  wire logic load_sense_above_excess_current_high_i,
    input  wire logic load_sense_above_short_i,
    input  wire logic load_sense_below_abnormal_charge_level_i,
    input  wire logic charger_above_zero_volt_charge_start_level_i,
    // switch enables
    output logic      charge_en_o,
    output logic      discharge_en_o,
    output logic      charge_gate_at_supply_o
);
    // ****************************************
    // input synchronisers
    // ****************************************
    logic [9:0] raw_in;
    logic [9:0] s;
    assign raw_in = {above_overcharge_threshold_i, below_overcharge_release_level_i,
                     below_overdischarge_threshold_i, above_overdischarge_release_level_i,
                     load_sense_below_charger_detect_i, load_sense_above_excess_current_low_i,
                     load_sense_above_excess_current_high_i, load_sense_above_short_i,
                     load_sense_below_abnormal_charge_level_i,
                     charger_above_zero_volt_charge_start_level_i};

    cpc_sync #(.WIDTH(10)) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (raw_in),
        .sync_o    (s)
    );

    logic ovc_hi;
    logic ovc_rel;
    logic ovd_lo;
    logic ovd_rel;
    logic chg_det;
    logic exc_lo;
    logic exc_hi;
    logic shrt;
    logic abn_clr;
    logic zv_chg;
    assign {ovc_hi, ovc_rel, ovd_lo, ovd_rel, chg_det, exc_lo, exc_hi, shrt, abn_clr, zv_chg} = s;

    // ****************************************
    // state and timers
    // ****************************************
    cpc_state_e state_ff;
    cpc_state_e nxt_state;
    logic       in_norm;
    logic       in_ovc;
    logic       in_ovd;
    assign in_norm = (state_ff == CPC_NORMAL);
    assign in_ovc  = (state_ff == CPC_OVERCHARGE);
    assign in_ovd  = (state_ff == CPC_OVERDISCHARGE);

    logic ovc_det_done;
    logic ovc_rst_done;
    logic ovc_rel_done;
    logic abn_done;
    logic ovd_det_done;
    logic ovd_rel_done;
    logic exl_done;
    logic exh_done;
    logic sht_done;

    // dip filter: detect timer holds through a dip, restarts only once the dip outlasts the reset delay
    cpc_timer #(.LIMIT(OVC_RST)) u_ovc_rst (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (in_norm && !ovc_hi),
        .clear_i   (!in_norm || ovc_hi),
        .done_o    (ovc_rst_done)
    );
    cpc_timer #(.LIMIT(OVC_DET)) u_ovc_det (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (in_norm && ovc_hi),
        .clear_i   (!in_norm || ovc_rst_done),
        .done_o    (ovc_det_done)
    );
    cpc_timer #(.LIMIT(OVC_REL)) u_ovc_rel (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (in_ovc && ovc_rel),
        .clear_i   (!(in_ovc && ovc_rel)),
        .done_o    (ovc_rel_done)
    );
    // abnormal charge only with discharge switch on and cell above threshold
    cpc_timer #(.LIMIT(ABN_DET)) u_abn (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (in_norm && chg_det && !ovd_lo),
        .clear_i   (!(in_norm && chg_det && !ovd_lo)),
        .done_o    (abn_done)
    );
    cpc_timer #(.LIMIT(OVD_DET)) u_ovd_det (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (in_norm && ovd_lo),
        .clear_i   (!(in_norm && ovd_lo)),
        .done_o    (ovd_det_done)
    );
    cpc_timer #(.LIMIT(OVD_REL)) u_ovd_rel (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (in_ovd && ovd_rel),
        .clear_i   (!(in_ovd && ovd_rel)),
        .done_o    (ovd_rel_done)
    );
    cpc_timer #(.LIMIT(EXL_DET)) u_exl (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (in_norm && exc_lo),
        .clear_i   (!(in_norm && exc_lo)),
        .done_o    (exl_done)
    );
    cpc_timer #(.LIMIT(EXH_DET)) u_exh (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (in_norm && exc_hi),
        .clear_i   (!(in_norm && exc_hi)),
        .done_o    (exh_done)
    );
    cpc_timer #(.LIMIT(SHT_DET)) u_sht (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (in_norm && shrt),
        .clear_i   (!(in_norm && shrt)),
        .done_o    (sht_done)
    );

    // ****************************************
    // state machine
    // ****************************************
    // discharge faults take priority over charge faults; a dead cell reaches zero-volt charge only from overdischarge
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CPC_NORMAL: begin
                if (sht_done || exh_done || exl_done) begin
                    nxt_state = CPC_EXCESS;
                end else if (ovd_det_done) begin
                    nxt_state = CPC_OVERDISCHARGE;
                end else if (ovc_det_done) begin
                    nxt_state = CPC_OVERCHARGE;
                end else if (abn_done) begin
                    nxt_state = CPC_ABNORMAL;
                end
            end
            CPC_OVERCHARGE: begin
                if (ovc_rel_done) begin
                    nxt_state = CPC_NORMAL;
                end else if (!chg_det && exc_lo && !ovc_hi) begin
                    nxt_state = CPC_NORMAL;
                end
            end
            CPC_ABNORMAL: begin
                if (abn_clr) begin
                    nxt_state = CPC_NORMAL;
                end
            end
            CPC_OVERDISCHARGE: begin
                if (chg_det && !ovd_lo) begin
                    nxt_state = CPC_NORMAL;
                end else if (!chg_det && !exc_lo && ovd_rel) begin
                    nxt_state = CPC_NORMAL;
                end else if (ovd_rel_done) begin
                    nxt_state = CPC_NORMAL;
                end else if (zv_chg && ovd_lo) begin
                    nxt_state = CPC_ZERO_VOLT;
                end
            end
            CPC_EXCESS: begin
                if (!exc_lo) begin
                    nxt_state = CPC_NORMAL;
                end
            end
            CPC_ZERO_VOLT: begin
                if (!ovd_lo) begin
                    nxt_state = CPC_NORMAL;
                end
            end
            default: nxt_state = CPC_NORMAL;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff <= CPC_NORMAL;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // switch outputs
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            charge_en_o             <= 1'h0;
            discharge_en_o          <= 1'h0;
            charge_gate_at_supply_o <= 1'h0;
        end else begin
            charge_en_o             <= (nxt_state != CPC_OVERCHARGE) && (nxt_state != CPC_ABNORMAL);
            discharge_en_o          <= (nxt_state == CPC_NORMAL) || (nxt_state == CPC_OVERCHARGE)
                                       || (nxt_state == CPC_ABNORMAL);
            charge_gate_at_supply_o <= (nxt_state == CPC_ZERO_VOLT);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_zero_volt_outputs;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_ZERO_VOLT) |-> (!discharge_en_o && charge_gate_at_supply_o);
    endproperty
    a_zero_volt_outputs: assert property (p_zero_volt_outputs) else $error("zero-volt outputs wrong");

    property p_normal_both_on;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_NORMAL) && !$past(rst_i) |-> (charge_en_o && discharge_en_o);
    endproperty
    a_normal_both_on: assert property (p_normal_both_on) else $error("normal state switch off");

    property p_overcharge_charge_off;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_OVERCHARGE) |-> !charge_en_o && discharge_en_o;
    endproperty
    a_overcharge_charge_off: assert property (p_overcharge_charge_off) else $error("overcharge charge on");

    property p_excess_discharge_off;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_EXCESS) |-> !discharge_en_o;
    endproperty
    a_excess_discharge_off: assert property (p_excess_discharge_off) else $error("excess discharge on");

    property p_excess_recover;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_EXCESS) && !exc_lo |=> (state_ff == CPC_NORMAL);
    endproperty
    a_excess_recover: assert property (p_excess_recover) else $error("excess not recovered");

    property p_abnormal_release;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_ABNORMAL) && abn_clr |=> (state_ff == CPC_NORMAL) ##1 charge_en_o;
    endproperty
    a_abnormal_release: assert property (p_abnormal_release) else $error("abnormal not released");

    property p_zero_volt_exit;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_ZERO_VOLT) && !ovd_lo |=> (state_ff == CPC_NORMAL);
    endproperty
    a_zero_volt_exit: assert property (p_zero_volt_exit) else $error("zero-volt not exited");

    property p_charger_detect_release;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_OVERDISCHARGE) && chg_det && !ovd_lo |=> ##1 discharge_en_o;
    endproperty
    a_charger_detect_release: assert property (p_charger_detect_release) else $error("charger detect failed");

    property p_no_early_overcharge;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(state_ff == CPC_OVERCHARGE) |-> $past(ovc_det_done);
    endproperty
    a_no_early_overcharge: assert property (p_no_early_overcharge) else $error("overcharge too early");

    property p_overdischarge_entry;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(state_ff == CPC_OVERDISCHARGE) |-> $past(ovd_det_done) ##1 !discharge_en_o;
    endproperty
    a_overdischarge_entry: assert property (p_overdischarge_entry) else $error("overdischarge entry wrong");

    property p_excess_entry;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(state_ff == CPC_EXCESS) |-> $past(sht_done || exh_done || exl_done) && !discharge_en_o;
    endproperty
    a_excess_entry: assert property (p_excess_entry) else $error("excess entered without timer");

    property p_abnormal_entry;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(state_ff == CPC_ABNORMAL) |-> $past(abn_done) && !charge_en_o && discharge_en_o;
    endproperty
    a_abnormal_entry: assert property (p_abnormal_entry) else $error("abnormal entry wrong");

    property p_overcharge_release;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_OVERCHARGE) && ovc_rel_done |=> (state_ff == CPC_NORMAL) && charge_en_o;
    endproperty
    a_overcharge_release: assert property (p_overcharge_release) else $error("overcharge not released");

    property p_load_release;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_OVERCHARGE) && !chg_det && exc_lo && !ovc_hi |=> (state_ff == CPC_NORMAL) && charge_en_o;
    endproperty
    a_load_release: assert property (p_load_release) else $error("load did not release charge");

    property p_release_timer;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state_ff == CPC_OVERDISCHARGE) && ovd_rel_done |=> (state_ff == CPC_NORMAL) && discharge_en_o;
    endproperty
    a_release_timer: assert property (p_release_timer) else $error("release timer ignored");
endmodule

// ===== cpc_pkg.sv
package cpc_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ                 = 25000000;
    localparam int OVC_DET_US             = 66000;
    localparam int OVC_RST_US             = 23000;
    localparam int OVC_REL_US             = 25000;
    localparam int ABN_DET_US             = 10000;
    localparam int OVD_DET_US             = 75000;
    localparam int OVD_REL_US             = 2200;
    localparam int EXL_DET_US             = 7800;
    localparam int EXH_DET_US             = 1100;
    localparam int SHT_DET_US             = 140;
    localparam int CYC_PER_US             = CLK_HZ / 1000000;
    localparam int OVC_DET_CYC            = OVC_DET_US * CYC_PER_US;
    localparam int OVC_RST_CYC            = OVC_RST_US * CYC_PER_US;
    localparam int OVC_REL_CYC            = OVC_REL_US * CYC_PER_US;
    localparam int ABN_DET_CYC            = ABN_DET_US * CYC_PER_US;
    localparam int OVD_DET_CYC            = OVD_DET_US * CYC_PER_US;
    localparam int OVD_REL_CYC            = OVD_REL_US * CYC_PER_US;
    localparam int EXL_DET_CYC            = EXL_DET_US * CYC_PER_US;
    localparam int EXH_DET_CYC            = EXH_DET_US * CYC_PER_US;
    localparam int SHT_DET_CYC            = SHT_DET_US * CYC_PER_US;
    localparam int CNT_W                  = 24;

    // ****************************************
    // states
    // ****************************************
    typedef enum logic [2:0] {
        CPC_NORMAL,
        CPC_OVERCHARGE,
        CPC_ABNORMAL,
        CPC_OVERDISCHARGE,
        CPC_EXCESS,
        CPC_ZERO_VOLT
    } cpc_state_e;
endpackage

// ===== cpc_sync.sv
`timescale 1ns/1ns
module cpc_sync
    import cpc_pkg::*;
#(
    parameter int WIDTH = 10
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;

    // first stage feeds only the second
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_o  <= '0;
        end else begin
            meta_ff <= async_i;
            sync_o  <= meta_ff;
        end
    end
endmodule

// ===== cpc_timer.sv
`timescale 1ns/1ns
module cpc_timer
    import cpc_pkg::*;
#(
    parameter int LIMIT = 16
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic run_i,
    input  wire logic clear_i,
    output logic      done_o
);
    logic [CNT_W-1:0] cnt_ff;

    // counts while run until LIMIT is reached, holds when not run, clears on clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || clear_i) begin
            cnt_ff <= '0;
        end else if (run_i && !done_o) begin
            cnt_ff <= cnt_ff + 1'h1;
        end
    end

    assign done_o = (cnt_ff >= CNT_W'(LIMIT));
endmodule

// ===== cpc_analog_model.sv
`timescale 1ns/1ns
module cpc_analog_model #(
    parameter int OVC_MV     = 4300,
    parameter int OVC_REL_MV = 4100,
    parameter int OVD_MV     = 2300,
    parameter int OVD_REL_MV = 2500,
    parameter int CHG_DET_MV = -80,
    parameter int EXL_MV     = 100,
    parameter int EXH_MV     = 400,
    parameter int SHT_MV     = 800,
    parameter int ABN_MV     = 50,
    parameter int ZV_MV      = 1200
) (
    // analog levels in millivolts
    input  int   cell_mv_i,
    input  int   load_mv_i,
    input  int   chg_mv_i,
    // comparator flags
    output logic ovc_o,
    output logic ovc_rel_o,
    output logic ovd_o,
    output logic ovd_rel_o,
    output logic chg_det_o,
    output logic exl_o,
    output logic exh_o,
    output logic sht_o,
    output logic abn_o,
    output logic zv_o
);
    // ****************************************
    // ideal comparators, no hysteresis
    // ****************************************
    // thresholds are plain picks: only their order matters to the controller
    assign ovc_o     = cell_mv_i > OVC_MV;
    assign ovc_rel_o = cell_mv_i < OVC_REL_MV;
    assign ovd_o     = cell_mv_i < OVD_MV;
    assign ovd_rel_o = cell_mv_i >= OVD_REL_MV;
    assign chg_det_o = load_mv_i < CHG_DET_MV;
    assign exl_o     = load_mv_i >= EXL_MV;
    assign exh_o     = load_mv_i >= EXH_MV;
    assign sht_o     = load_mv_i >= SHT_MV;
    assign abn_o     = ((load_mv_i < 0) ? -load_mv_i : load_mv_i) < ABN_MV;
    assign zv_o      = chg_mv_i >= ZV_MV;
endmodule

// ===== tb_cpc_top.sv
`timescale 1ns/1ns
module tb_cpc_top;
    import cpc_pkg::*;
    // short counts keep the run small; order not kept as the real delays (excess-low outlasts overcharge release here)
    localparam int P_OD = 20, P_OR = 8, P_OL = 10, P_AB = 6, P_DD = 20;
    localparam int P_DL = 5, P_EL = 12, P_EH = 6, P_SH = 3;
    logic sys_clk, rst;
    int   cell_mv, load_mv, chg_mv, n_errors, checked;
    logic ovc, ovc_rel, ovd, ovd_rel, chg_det, exl, exh, sht, abn, zv;
    logic charge_en, discharge_en, gate;

    // ****************************************
    // far side and design
    // ****************************************
    cpc_analog_model i_model (.cell_mv_i(cell_mv), .load_mv_i(load_mv), .chg_mv_i(chg_mv),
        .ovc_o(ovc), .ovc_rel_o(ovc_rel), .ovd_o(ovd), .ovd_rel_o(ovd_rel), .chg_det_o(chg_det),
        .exl_o(exl), .exh_o(exh), .sht_o(sht), .abn_o(abn), .zv_o(zv));
    cpc_top #(.OVC_DET(P_OD), .OVC_RST(P_OR), .OVC_REL(P_OL), .ABN_DET(P_AB), .OVD_DET(P_DD),
        .OVD_REL(P_DL), .EXL_DET(P_EL), .EXH_DET(P_EH), .SHT_DET(P_SH)) i_dut (
        .sys_clk_i(sys_clk), .rst_i(rst), .above_overcharge_threshold_i(ovc),
        .below_overcharge_release_level_i(ovc_rel), .below_overdischarge_threshold_i(ovd),
        .above_overdischarge_release_level_i(ovd_rel), .load_sense_below_charger_detect_i(chg_det),
        .load_sense_above_excess_current_low_i(exl), .load_sense_above_excess_current_high_i(exh),
        .load_sense_above_short_i(sht), .load_sense_below_abnormal_charge_level_i(abn),
        .charger_above_zero_volt_charge_start_level_i(zv), .charge_en_o(charge_en),
        .discharge_en_o(discharge_en), .charge_gate_at_supply_o(gate));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic print_verdict();
        if (n_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic report(input string msg);
        n_errors++;
        $display("Error at %0t: %s", $time, msg);
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return charge_en;
            1: return discharge_en;
            default: return gate;
        endcase
    endfunction
    task automatic check_out(input int sel, input logic exp);
        checked++;
        if (pick(sel) !== exp) report($sformatf("output %0d not %0b", sel, exp));
    endtask
    // counts edges until the output takes its new level; early and late both fail
    task automatic wait_out(input int sel, input logic exp, input int lo, input int hi);
        int n;
        n = 0;
        while (pick(sel) !== exp && n < hi) begin
            @(posedge sys_clk);
            #2;
            n++;
        end
        checked++;
        if (pick(sel) !== exp) begin
            report($sformatf("output %0d never reached %0b", sel, exp));
            print_verdict();
        end else if (n < lo) report($sformatf("output %0d changed early after %0d", sel, n));
    endtask
    task automatic hold_out(input int sel, input logic exp, input int cyc);
        repeat (cyc) begin
            @(posedge sys_clk);
            #2;
            check_out(sel, exp);
        end
    endtask
    task automatic drive(input int c, input int l, input int g);
        @(posedge sys_clk);
        #1;
        cell_mv = c;
        load_mv = l;
        chg_mv  = g;
    endtask
    task automatic to_normal();
        drive(3700, 0, 0);
        wait_out(0, 1'b1, 0, 60);
        wait_out(1, 1'b1, 0, 60);
        wait_out(2, 1'b0, 0, 60);
    endtask
    task automatic go_overdischarge(input int l);
        drive(2000, l, 0);
        wait_out(1, 1'b0, P_DD, P_DD + 5);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_overcharge();
        drive(4400, 0, 0);
        wait_out(0, 1'b0, P_OD, P_OD + 5);
        check_out(1, 1'b1);
        drive(4000, 0, 0);
        wait_out(0, 1'b1, P_OL, P_OL + 5);
    endtask
    task automatic t_dip();
        drive(4400, 0, 0);
        repeat (10) @(posedge sys_clk);
        drive(4200, 0, 0);
        repeat (3) @(posedge sys_clk);
        drive(4400, 0, 0);
        wait_out(0, 1'b0, 1, P_OD - 4);
        to_normal();
        drive(4400, 0, 0);
        repeat (10) @(posedge sys_clk);
        drive(4200, 0, 0);
        repeat (P_OR + 6) @(posedge sys_clk);
        drive(4400, 0, 0);
        wait_out(0, 1'b0, P_OD, P_OD + 5);
    endtask
    task automatic t_load_after();
        drive(4400, 0, 0);
        wait_out(0, 1'b0, P_OD, P_OD + 5);
        drive(4200, 150, 0);
        wait_out(0, 1'b1, 1, 6);
    endtask
    task automatic t_abnormal();
        drive(3700, -100, 0);
        wait_out(0, 1'b0, P_AB, P_AB + 5);
        check_out(1, 1'b1);
        drive(3700, 0, 0);
        wait_out(0, 1'b1, 1, 6);
    endtask
    task automatic t_release();
        go_overdischarge(0);
        check_out(0, 1'b1);
        drive(2600, 150, 0);
        wait_out(1, 1'b1, P_DL, P_DL + 5);
        to_normal();
        go_overdischarge(20);
        drive(2400, 20, 0);
        hold_out(1, 1'b0, 15);
        drive(2600, 20, 0);
        wait_out(1, 1'b1, 1, 6);
    endtask
    task automatic t_charger();
        go_overdischarge(-100);
        hold_out(0, 1'b1, P_AB + 8);
        drive(2400, -100, 0);
        wait_out(1, 1'b1, 1, 6);
    endtask
    task automatic t_excess();
        int lv[3];
        int lim[3];
        lv  = '{150, 500, 900};
        lim = '{P_EL, P_EH, P_SH};
        for (int i = 0; i < 3; i++) begin
            drive(3700, lv[i], 0);
            wait_out(1, 1'b0, lim[i], lim[i] + 5);
            check_out(0, 1'b1);
            drive(3700, 0, 0);
            wait_out(1, 1'b1, 1, 6);
        end
    endtask
    task automatic t_zero_volt();
        go_overdischarge(0);
        drive(2000, 0, 1500);
        wait_out(2, 1'b1, 1, 6);
        check_out(0, 1'b1);
        check_out(1, 1'b0);
        drive(2400, 0, 1500);
        wait_out(2, 1'b0, 1, 6);
        check_out(1, 1'b1);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        n_errors = 0;
        checked  = 0;
        rst      = 1'b1;
        cell_mv  = 3700;
        load_mv  = 0;
        chg_mv   = 0;
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        wait_out(0, 1'b1, 1, 2);
        check_out(1, 1'b1);
        t_overcharge();
        to_normal();
        t_dip();
        to_normal();
        t_load_after();
        to_normal();
        t_abnormal();
        to_normal();
        t_release();
        to_normal();
        t_charger();
        to_normal();
        t_excess();
        t_zero_volt();
        to_normal();
        print_verdict();
    end
endmodule
